// ### single_wire_dimming_receiver_tb.sv
module single_wire_dimming_receiver_tb
  import swdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened so that the whole run stays near the cycle budget
  localparam int         EN_SD    = 9000;
  localparam int         DUTY_SD  = 9000;
  localparam int         LIM      = 4000;
  localparam int         ACKLEN   = 2000;
  // Legal cells of 6us and 20us keep three commands inside the cycle budget
  localparam int         BIT_SHORT = 150;
  localparam int         BIT_LONG  = 500;
  // Arbitrary value
  localparam logic [7:0] DEV_ADDR = 8'h5a;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, duty_in, serr;
  logic        device_on, wire_mode, startup_current_cap, cmd_ok, cmd_bad;
  logic [7:0]  paddr;
  logic [8:0]  dim_code;
  logic [31:0] pwdata, prdata, q;
  int          n_mismatch, checked;
  int          n_ok, n_bad;

  swdr_if link_if ();
  swdr_host #(.P_SHORT(swdr_cnt_t'(BIT_SHORT)), .P_LONG(swdr_cnt_t'(BIT_LONG))) swdr_host_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus(link_if));
  swdr_device #(.P_ACK(swdr_cnt_t'(ACKLEN)), .P_EN_SD(swdr_cnt_t'(EN_SD)), .P_DUTY_SD(swdr_cnt_t'(DUTY_SD)),
    .P_LIM_HOLD(swdr_cnt_t'(LIM)), .TARGET_ADDR(DEV_ADDR)) swdr_device_inst (.pclk, .presetn, .bus(link_if),
    .duty_in, .device_on, .wire_mode, .dim_code, .startup_current_cap, .cmd_ok, .cmd_bad);
  swdr_sva #(.P_ACK(ACKLEN), .P_EN_SD(EN_SD), .P_DUTY_SD(DUTY_SD), .P_LIM_HOLD(LIM)) swdr_sva_inst (.pclk,
    .presetn, .line(link_if.line), .host_oe(link_if.host_oe), .dev_oe(link_if.dev_oe), .dev_out(link_if.dev_out),
    .duty_in, .device_on, .wire_mode, .dim_code, .startup_current_cap, .cmd_ok, .cmd_bad);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Counts the one-cycle verdict pulses so each command can be judged
  always_ff @(posedge pclk) begin
    n_ok  <= n_ok + int'(cmd_ok);
    n_bad <= n_bad + int'(cmd_bad);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 40000);
    chk(q[b], 1'b1, "status wait");
  endtask

  task automatic t_reset();
    chk(dim_code, 9'h1ff, "reset code");
    chk(device_on, 1'b0, "off in reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk(serr, 1'b1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_detect();
    apb(1'b1, REG_CTRL, 32'h3);
    // Duty input follows the enable rise, so power-up opens the detect window
    repeat (2) @(posedge pclk);
    duty_in <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(device_on, 1'b1, "enable start");
    chk(startup_current_cap, 1'b1, "reduced limit");
    wait_stat(STAT_READY);
    @(posedge pclk);
    chk(wire_mode, 1'b1, "command mode");
    chk(startup_current_cap, 1'b0, "normal limit");
    $display("test detect done");
  endtask

  task automatic t_cmd(input logic [7:0] adr, input logic rq, input logic [8:0] dim, input logic [8:0] dim_exp,
                       input logic ack_exp);
    int ok0;
    int bad0;
    ok0  = n_ok;
    bad0 = n_bad;
    apb(1'b1, REG_STAT, 32'h1 << STAT_DONE);
    apb(1'b1, REG_CMD, {8'h0, adr, 5'h0, rq, 1'b0, dim});
    apb(1'b1, REG_CTRL, 32'h7);
    wait_stat(STAT_DONE);
    chk(q[STAT_ACK], ack_exp, "acknowledge");
    chk(q[STAT_LINE], 1'b1, "line released");
    chk(dim_code, dim_exp, "dim code");
    chk(n_ok - ok0, 32'(adr == DEV_ADDR), "accept pulse");
    chk(n_bad - bad0, 32'(adr != DEV_ADDR), "reject pulse");
    $display("test command %h done", adr);
  endtask

  task automatic t_power();
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (EN_SD - 200) @(posedge pclk);
    chk(device_on, 1'b1, "early enable shutdown");
    repeat (400) @(posedge pclk);
    chk(device_on, 1'b0, "enable shutdown");
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (50) @(posedge pclk);
    chk(device_on, 1'b1, "plain enable");
    chk(wire_mode, 1'b0, "plain mode");
    duty_in <= 1'b0;
    repeat (DUTY_SD - 200) @(posedge pclk);
    chk(device_on, 1'b1, "early duty shutdown");
    repeat (400) @(posedge pclk);
    chk(device_on, 1'b0, "duty shutdown");
    $display("test power done");
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    duty_in = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_detect();
    t_cmd(DEV_ADDR, 1'b1, 9'h0a5, 9'h0a5, 1'b1);
    t_cmd(8'ha5, 1'b1, 9'h155, 9'h0a5, 1'b0);
    t_cmd(DEV_ADDR, 1'b0, 9'h000, 9'h000, 1'b0);
    t_power();
    test_done();
  end
endmodule

// ### swdr_device.sv
// Function
// - Long low, short high cell decodes zero
// - Short low, long high cell decodes one
// - Detect needs 100us high, 260us low
// - Line high 2us before command start
// - End-of-stream low 2 to 360us
// - Acknowledge starts early, lasts at most 512us
// - Acknowledge only when request flag set
// - Acknowledge pulls low; failure leaves line released
// - Master drives open-drain and releases line
// - Enable high starts; 2.5ms low stops
// - Duty input low 20ms stops device
// - Reduced current limit for 6ms at start
// - Cells run from falling edge to falling
// - 24 bits LSB first, address must match
// - Dim code all ones at first enable
// - Command mode only after detect window pattern
//
// The register addresses and the APB slave port are this design's own decisions.
module swdr_device
  import swdr_pkg::*;
#(
  parameter swdr_cnt_t  P_CELL_HALF = swdr_cnt_t'(C_CELL_HALF),
  parameter swdr_cnt_t  P_CELL_MAX  = swdr_cnt_t'(C_CELL_MAX),
  parameter swdr_cnt_t  P_DETECT    = swdr_cnt_t'(C_DETECT),
  parameter swdr_cnt_t  P_WIN       = swdr_cnt_t'(C_WIN),
  parameter swdr_cnt_t  P_ACK       = swdr_cnt_t'(C_ACK),
  parameter swdr_cnt_t  P_EN_SD     = swdr_cnt_t'(C_EN_SD),
  parameter swdr_cnt_t  P_DUTY_SD   = swdr_cnt_t'(C_DUTY_SD),
  parameter swdr_cnt_t  P_LIM_HOLD  = swdr_cnt_t'(C_LIM_HOLD),
  // Arbitrary value
  parameter logic [7:0] TARGET_ADDR = 8'h5a
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  swdr_if.dev             bus,
  input  wire logic       duty_in,
  output logic            device_on,
  output logic            wire_mode,
  output logic [8:0]      dim_code,
  output logic            startup_current_cap,
  output logic            cmd_ok,
  output logic            cmd_bad
);
  localparam swdr_cnt_t L_MIN   = swdr_cnt_t'(C_CELL_MIN);
  localparam swdr_cnt_t L_DELAY = swdr_cnt_t'(C_DELAY);
  localparam swdr_cnt_t L_LEAD  = swdr_cnt_t'(C_LEAD);
  localparam swdr_cnt_t L_ADLY  = swdr_cnt_t'(C_ACK_DLY);

  swdr_dstate_t        state;
  logic                en;
  logic                en_q;
  logic                rise;
  logic                fall;
  logic                line_edge;
  swdr_cnt_t           level_cnt;
  swdr_cnt_t           duty_cnt;
  swdr_cnt_t           on_cnt;
  swdr_cnt_t           low_len;
  logic                want_off;
  logic                on_start;
  logic [4:0]          bit_idx;
  logic [CMD_BITS-1:0] shreg;
  logic                cell_bad;
  logic                cmd_good;
  logic                eos_decide;
  logic [1:0]          cell_class;

  assign en        = bus.line;
  assign rise      = en && !en_q;
  assign fall      = !en && en_q;
  assign line_edge = en != en_q;

  // Returns {valid, value} for one cell
  function automatic logic [1:0] classify(input swdr_cnt_t hi, input swdr_cnt_t lo);
    logic [SWDR_TW+1:0] hi3;
    logic [SWDR_TW+1:0] lo3;
    logic               zero_ok;
    logic               one_ok;
    hi3     = {1'b0, hi, 1'b0} + {2'b00, hi};
    lo3     = {1'b0, lo, 1'b0} + {2'b00, lo};
    zero_ok = (hi >= L_MIN) && (hi <= P_CELL_HALF) && ({2'b00, lo} >= hi3) && (lo <= P_CELL_MAX);
    one_ok  = (lo >= L_MIN) && (lo <= P_CELL_HALF) && ({2'b00, hi} >= lo3) && (hi <= P_CELL_MAX);
    classify = {zero_ok || one_ok, one_ok};
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en;
    end
  end

  // Length of the present line level, restarted at each edge
  swdr_timer #(.W(SWDR_TW)) u_level (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (line_edge),
    .count   (level_cnt)
  );

  swdr_timer #(.W(SWDR_TW)) u_duty (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (duty_in),
    .count   (duty_cnt)
  );

  // Time since power-up, shared by the detect window and the current cap
  swdr_timer #(.W(SWDR_TW)) u_since_on (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (on_start),
    .count   (on_cnt)
  );

  // A low level shuts down even while the other pin is high
  assign want_off = (!en && level_cnt > P_EN_SD) || (!duty_in && duty_cnt > P_DUTY_SD);
  assign on_start = !device_on && (en || duty_in) && !want_off;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_on <= 1'b0;
    end else if (want_off) begin
      device_on <= 1'b0;
    end else if (en || duty_in) begin
      device_on <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_current_cap <= 1'b0;
    end else begin
      startup_current_cap <= on_start || (device_on && !want_off && on_cnt < P_LIM_HOLD);
    end
  end

  assign cell_class = classify(level_cnt, low_len);
  assign cmd_good   = !cell_bad && (shreg[ADDR_LSB +: ADDR_W] == TARGET_ADDR);
  assign eos_decide = (state == D_EOS) && (rise || level_cnt == L_ADLY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= D_OFF;
      bit_idx  <= '0;
      shreg    <= '0;
      low_len  <= '0;
      cell_bad <= 1'b0;
    end else if (want_off) begin
      state <= D_OFF;
    end else if (on_start) begin
      state <= en ? D_WHIGH : D_PLAIN;
    end else begin
      case (state)
        D_OFF: begin
          state <= D_OFF;
        end
        D_WHIGH: begin
          if (on_cnt > P_WIN) begin
            state <= D_PLAIN;
          end else if (fall) begin
            state <= (level_cnt >= L_DELAY) ? D_WLOW : D_PLAIN;
          end
        end
        D_WLOW: begin
          if (on_cnt > P_WIN) begin
            state <= D_PLAIN;
          end else if (rise) begin
            state <= (level_cnt >= P_DETECT) ? D_IDLE : D_PLAIN;
          end
        end
        D_PLAIN: begin
          state <= D_PLAIN;
        end
        D_IDLE: begin
          if (fall && level_cnt >= L_LEAD) begin
            state    <= D_BIT;
            bit_idx  <= '0;
            cell_bad <= 1'b0;
          end
        end
        D_BIT: begin
          if (!line_edge && level_cnt > P_CELL_MAX) begin
            state <= D_IDLE;
          end else if (rise) begin
            low_len <= level_cnt;
          end else if (fall) begin
            shreg[bit_idx] <= cell_class[0];
            if (!cell_class[1]) begin
              cell_bad <= 1'b1;
            end
            if (bit_idx == 5'(CMD_BITS - 1)) begin
              state <= D_EOS;
            end else begin
              bit_idx <= bit_idx + 1'b1;
            end
          end
        end
        D_EOS: begin
          if (eos_decide) begin
            state <= (shreg[ACKREQ_BIT] && cmd_good) ? D_ACK : D_IDLE;
          end else if (level_cnt > P_CELL_MAX) begin
            state <= D_IDLE;
          end
        end
        D_ACK: begin
          // Counted from the start of end-of-stream, so the hold never exceeds the limit
          if (level_cnt >= P_ACK) begin
            state <= D_IDLE;
          end
        end
        default: begin
          state <= D_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dim_code <= DIM_RESET;
    end else if (on_start) begin
      dim_code <= DIM_RESET;
    end else if (eos_decide && cmd_good) begin
      dim_code <= shreg[DIM_LSB +: DIM_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ok  <= 1'b0;
      cmd_bad <= 1'b0;
    end else begin
      cmd_ok  <= eos_decide && cmd_good;
      cmd_bad <= eos_decide && !cmd_good;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_mode <= 1'b0;
    end else begin
      wire_mode <= !want_off && !on_start && (state inside {D_IDLE, D_BIT, D_EOS, D_ACK});
    end
  end

  // Open drain: only ever pulls low
  assign bus.dev_out = 1'b0;
  assign bus.dev_oe  = (state == D_ACK);
endmodule

// ### swdr_host.sv
module swdr_host
  import swdr_pkg::*;
#(
  parameter swdr_cnt_t P_DLOW  = swdr_cnt_t'(C_H_DLOW),
  parameter swdr_cnt_t P_SHORT = swdr_cnt_t'(C_H_SHORT),
  parameter swdr_cnt_t P_LONG  = swdr_cnt_t'(C_H_LONG)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  swdr_if.host             bus
);
  localparam swdr_cnt_t L_DHIGH = swdr_cnt_t'(C_H_DHIGH);
  localparam swdr_cnt_t L_LEAD  = swdr_cnt_t'(C_H_LEAD);
  localparam swdr_cnt_t L_EOS   = swdr_cnt_t'(C_EOS);
  localparam swdr_cnt_t L_SMP   = swdr_cnt_t'(C_H_ACK_SMP);

  swdr_hstate_t        state;
  swdr_cnt_t           tcnt;
  logic                ctrl_en;
  logic                ctrl_wire;
  logic                go_send;
  logic [CMD_BITS-1:0] cmd;
  logic [4:0]          idx;
  logic                ready;
  logic                done;
  logic                ack_seen;
  logic                busy;
  logic                wr;
  logic                mapped;
  logic                set_done;

  assign wr      = psel && penable && pwrite;
  assign mapped  = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign busy    = !(state inside {H_OFF, H_IDLE});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en   <= 1'b0;
      ctrl_wire <= 1'b0;
      go_send   <= 1'b0;
      cmd       <= '0;
    end else begin
      go_send <= 1'b0;
      if (wr && paddr == REG_CTRL) begin
        ctrl_en   <= pwdata[CTRL_EN];
        ctrl_wire <= pwdata[CTRL_WIRE];
        go_send   <= pwdata[CTRL_SEND];
      end
      // A command is frozen while it is on the line
      if (wr && paddr == REG_CMD && !busy) begin
        cmd <= pwdata[CMD_BITS-1:0];
      end
    end
  end

  // Read data is captured in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        REG_CTRL: prdata <= {29'h0000000, 1'b0, ctrl_wire, ctrl_en};
        REG_CMD:  prdata <= {8'h00, cmd};
        REG_STAT: prdata <= {27'h0000000, bus.line, ack_seen, done, ready, busy};
        default:  prdata <= '0;
      endcase
    end
  end

  assign set_done = (state == H_REL) && bus.line;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (set_done) begin
      done <= 1'b1;
    end else if (wr && paddr == REG_STAT && pwdata[STAT_DONE]) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= H_OFF;
      tcnt     <= '0;
      idx      <= '0;
      ready    <= 1'b0;
      ack_seen <= 1'b0;
    end else if (!ctrl_en) begin
      state <= H_OFF;
      tcnt  <= '0;
      ready <= 1'b0;
    end else begin
      tcnt <= tcnt + 1'b1;
      case (state)
        H_OFF: begin
          tcnt  <= '0;
          state <= ctrl_wire ? H_DHIGH : H_IDLE;
        end
        H_DHIGH: begin
          if (tcnt >= L_DHIGH) begin
            state <= H_DLOW;
            tcnt  <= '0;
          end
        end
        H_DLOW: begin
          if (tcnt >= P_DLOW) begin
            state <= H_IDLE;
            ready <= 1'b1;
          end
        end
        H_IDLE: begin
          if (go_send && ready) begin
            state    <= H_LEAD;
            tcnt     <= '0;
            ack_seen <= 1'b0;
          end
        end
        H_LEAD: begin
          if (tcnt >= L_LEAD) begin
            state <= H_BLOW;
            tcnt  <= '0;
            idx   <= '0;
          end
        end
        H_BLOW: begin
          if (tcnt >= (cmd[idx] ? P_SHORT : P_LONG)) begin
            state <= H_BHIGH;
            tcnt  <= '0;
          end
        end
        H_BHIGH: begin
          if (tcnt >= (cmd[idx] ? P_LONG : P_SHORT)) begin
            tcnt <= '0;
            if (idx == 5'(CMD_BITS - 1)) begin
              state <= H_EOS;
            end else begin
              idx   <= idx + 1'b1;
              state <= H_BLOW;
            end
          end
        end
        H_EOS: begin
          if (tcnt >= L_EOS) begin
            state <= cmd[ACKREQ_BIT] ? H_ACK : H_REL;
            tcnt  <= '0;
          end
        end
        H_ACK: begin
          if (tcnt >= L_SMP) begin
            ack_seen <= !bus.line;
            state    <= H_REL;
          end
        end
        H_REL: begin
          if (bus.line) begin
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_OFF;
        end
      endcase
    end
  end

  // Open drain: pulls low only, pull-up gives the high level
  assign bus.host_out = 1'b0;
  assign bus.host_oe  = state inside {H_OFF, H_DLOW, H_BLOW, H_EOS};
endmodule

// ### swdr_if.sv
interface swdr_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;

  // Wired line with pull-up: either end pulling low wins
  assign line = !((host_oe && !host_out) || (dev_oe && !dev_out));

  modport dev (input line, output dev_out, output dev_oe);
  modport host (input line, output host_out, output host_oe);
endinterface

// ### swdr_pkg.sv
package swdr_pkg;
  localparam int CLK_MHZ = 25;
  localparam int SWDR_TW = 20;
  typedef logic [SWDR_TW-1:0] swdr_cnt_t;

  // Cell timing
  localparam int T_CELL_MIN_US  = 5;
  localparam int C_CELL_MIN     = T_CELL_MIN_US * CLK_MHZ;
  localparam int T_CELL_HALF_US = 180;
  localparam int C_CELL_HALF    = T_CELL_HALF_US * CLK_MHZ;
  localparam int T_CELL_MAX_US  = 360;
  localparam int C_CELL_MAX     = T_CELL_MAX_US * CLK_MHZ;

  // Detection sequence
  localparam int T_DELAY_US  = 100;
  localparam int C_DELAY     = T_DELAY_US * CLK_MHZ;
  localparam int T_DETECT_US = 260;
  localparam int C_DETECT    = T_DETECT_US * CLK_MHZ;
  localparam int T_WIN_MS    = 1;
  localparam int C_WIN       = T_WIN_MS * 1000 * CLK_MHZ;

  // Command framing and acknowledge
  localparam int T_LEAD_US    = 2;
  localparam int C_LEAD       = T_LEAD_US * CLK_MHZ;
  localparam int T_EOS_US     = 2;
  localparam int C_EOS        = T_EOS_US * CLK_MHZ;
  localparam int T_ACK_VAL_US = 2;
  // Pull-down starts halfway into the allowed start time
  localparam int C_ACK_DLY    = T_ACK_VAL_US * CLK_MHZ / 2;
  localparam int T_ACK_US     = 512;
  localparam int C_ACK        = T_ACK_US * CLK_MHZ;

  // Power control
  localparam real T_EN_SD_MS    = 2.5;
  localparam int  C_EN_SD       = int'(T_EN_SD_MS * 1000.0 * CLK_MHZ);
  localparam int  T_DUTY_SD_MS  = 20;
  localparam int  C_DUTY_SD     = T_DUTY_SD_MS * 1000 * CLK_MHZ;
  localparam int  T_LIM_HOLD_MS = 6;
  localparam int  C_LIM_HOLD    = T_LIM_HOLD_MS * 1000 * CLK_MHZ;

  // Host side timing
  localparam int T_H_DHIGH_US   = 150;
  localparam int C_H_DHIGH      = T_H_DHIGH_US * CLK_MHZ;
  localparam int T_H_DLOW_US    = 300;
  localparam int C_H_DLOW       = T_H_DLOW_US * CLK_MHZ;
  localparam int T_H_LEAD_US    = 5;
  localparam int C_H_LEAD       = T_H_LEAD_US * CLK_MHZ;
  localparam int T_H_SHORT_US   = 10;
  localparam int C_H_SHORT      = T_H_SHORT_US * CLK_MHZ;
  localparam int T_H_LONG_US    = 40;
  localparam int C_H_LONG       = T_H_LONG_US * CLK_MHZ;
  localparam int T_H_ACK_SMP_US = 20;
  localparam int C_H_ACK_SMP    = T_H_ACK_SMP_US * CLK_MHZ;

  // Command layout
  localparam int         CMD_BITS   = 24;
  localparam int         DIM_LSB    = 0;
  localparam int         DIM_W      = 9;
  localparam int         ACKREQ_BIT = 10;
  localparam int         ADDR_LSB   = 16;
  localparam int         ADDR_W     = 8;
  localparam logic [8:0] DIM_RESET  = 9'h1ff;

  // Host registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam int         CTRL_EN    = 0;
  localparam int         CTRL_WIRE  = 1;
  localparam int         CTRL_SEND  = 2;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_READY = 1;
  localparam int         STAT_DONE  = 2;
  localparam int         STAT_ACK   = 3;
  localparam int         STAT_LINE  = 4;

  typedef enum logic [7:0] {
    D_OFF   = 8'h01,
    D_WHIGH = 8'h02,
    D_WLOW  = 8'h04,
    D_PLAIN = 8'h08,
    D_IDLE  = 8'h10,
    D_BIT   = 8'h20,
    D_EOS   = 8'h40,
    D_ACK   = 8'h80
  } swdr_dstate_t;

  typedef enum logic [9:0] {
    H_OFF   = 10'h001,
    H_IDLE  = 10'h002,
    H_DHIGH = 10'h004,
    H_DLOW  = 10'h008,
    H_LEAD  = 10'h010,
    H_BLOW  = 10'h020,
    H_BHIGH = 10'h040,
    H_EOS   = 10'h080,
    H_ACK   = 10'h100,
    H_REL   = 10'h200
  } swdr_hstate_t;
endpackage

// ### swdr_sva.sv
module swdr_sva #(
  parameter int P_ACK      = 12800,
  parameter int P_EN_SD    = 62500,
  parameter int P_DUTY_SD  = 500000,
  parameter int P_LIM_HOLD = 150000
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       line,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic       dev_out,
  input wire logic       duty_in,
  input wire logic       device_on,
  input wire logic       wire_mode,
  input wire logic [8:0] dim_code,
  input wire logic       startup_current_cap,
  input wire logic       cmd_ok,
  input wire logic       cmd_bad
);
  int lo_cnt;
  int duty_cnt;
  int cap_cnt;
  int ack_cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // lo_cnt and duty_cnt saturate so long idle stretches cannot wrap; cap_cnt and ack_cnt do not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt   <= 0;
      duty_cnt <= 0;
      cap_cnt  <= 0;
      ack_cnt  <= 0;
    end else begin
      lo_cnt   <= line ? 0 : lo_cnt + int'(lo_cnt < P_EN_SD + 8);
      duty_cnt <= duty_in ? 0 : duty_cnt + int'(duty_cnt < P_DUTY_SD + 8);
      cap_cnt  <= startup_current_cap ? cap_cnt + 1 : 0;
      ack_cnt  <= dev_oe ? ack_cnt + 1 : 0;
    end
  end

  a_ack_len: assert property (ack_cnt <= P_ACK + 2) else $error("acknowledge held too long");
  a_ack_start: assert property ($rose(dev_oe) |-> host_oe) else $error("acknowledge outside end of stream");
  a_ack_drive: assert property (dev_oe |-> !dev_out && !line) else $error("acknowledge not low");
  a_bad_no_ack: assert property (cmd_bad |-> !dev_oe [*8]) else $error("acknowledge after bad command");
  a_bad_code: assert property (cmd_bad |=> $stable(dim_code)) else $error("code changed on bad command");
  a_ack_mode: assert property (dev_oe |-> wire_mode && device_on) else $error("acknowledge outside command mode");
  a_en_off: assert property (lo_cnt > P_EN_SD + 2 |-> !device_on) else $error("no shutdown on enable low");
  a_duty_off: assert property (duty_cnt > P_DUTY_SD + 2 |-> !device_on) else $error("no shutdown on duty low");
  a_en_on: assert property ($rose(line) && duty_in |-> ##[0:4] device_on) else $error("no start on enable high");
  a_cap_rise: assert property ($rose(device_on) |-> ##[0:2] startup_current_cap) else $error("no reduced limit");
  a_cap_len: assert property (cap_cnt <= P_LIM_HOLD + 2) else $error("reduced limit held too long");
  a_dim_first: assert property ($rose(device_on) |-> ##[0:1] dim_code == 9'h1ff) else $error("code not reset");

  c_ack: cover property ($rose(dev_oe));
  c_ok: cover property (cmd_ok);
  c_bad: cover property (cmd_bad);
  c_off: cover property ($fell(device_on));
endmodule

// ### swdr_timer.sv
module swdr_timer
  import swdr_pkg::*;
#(
  parameter int W = SWDR_TW
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         restart,
  output logic [W-1:0]      count
);
  // Saturates so a very long level never wraps into a short one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (count != {W{1'b1}}) begin
      count <= count + 1'b1;
    end
  end
endmodule
